// ===== fault_blanking_burst_select_tb_top.sv
`default_nettype none
module fault_blanking_burst_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fbb_pkg::*;
  localparam int BL = 50;
  localparam int DC = 200;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic vcc_on, protect_active, restart_cycle, fb_ovl, fb_above_4v0, fb_above_3v5;
  logic fb_below_3v2, fb_below_entry, extend_mode, cap_en;
  logic [7:0] fb_rise, ext_rise;
  logic p_hi, p_lo, e_up, e_lo, ecs, eds, dds, dflag, lv, ba, bias, blim, fire, edone;
  logic [1:0] lvl;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 41;
  int rs[4] = '{60, 16, 5, 1};
  int n, nc, k;
  fbb_control #(.BLANK_CYCLES(BL), .DETECT_CYCLES(DC), .BOUND_HI(8'h02), .BOUND_MID(8'h06),
    .BOUND_LO(8'h0e)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .vcc_on(vcc_on),
    .protect_active(protect_active), .restart_cycle(restart_cycle),
    .fb_above_4v5(fb_ovl | p_hi), .fb_above_4v0(fb_above_4v0), .fb_above_3v5(fb_above_3v5),
    .fb_below_3v2(fb_below_3v2), .fb_below_entry(fb_below_entry), .fb_below_0v5(p_lo),
    .ext_upper_cmp(e_up), .ext_lower_cmp(e_lo), .extend_mode(extend_mode),
    .extend_charge_switch(ecs), .extend_discharge_switch(eds), .detect_discharge_switch(dds),
    .detect_flag(dflag), .burst_level(lvl), .level_valid(lv), .burst_active(ba),
    .bias_on(bias), .burst_limit_on(blim), .restart_fire(fire), .extension_done(edone));
  fbb_caps i_caps (.ref_clk(ref_clk), .cap_en(cap_en), .fb_rise(fb_rise), .ext_rise(ext_rise),
    .extend_charge_switch(ecs), .extend_discharge_switch(eds), .detect_discharge_switch(dds),
    .fb_hi(p_hi), .fb_lo(p_lo), .ext_upper_cmp(e_up), .ext_lower_cmp(e_lo));
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // detection count from the capacitor's charge and discharge time plus sync delay
  function automatic logic [1:0] exp_level(input int r);
    int c;
    c = (DC - r - 3) / (2 * r + 6) + 1;
    if (c <= 2)
      return LVL_160;
    if (c <= 6)
      return LVL_142;
    return (c <= 14) ? LVL_127 : LVL_NONE;
  endfunction
  task automatic tick(input int t);
    repeat (t) @(posedge ref_clk);
    #1;
  endtask
  task automatic boot(input int r, input logic rc, input logic pr);
    tick(1);
    nrst = 1'h0;
    {vcc_on, fb_ovl, fb_below_entry, fb_above_4v0, fb_above_3v5, fb_below_3v2, cap_en} = '0;
    restart_cycle = rc;
    protect_active = pr;
    fb_rise = 8'(r);
    tick(5);
    check(bias, 1);
    check(lvl, LVL_RESET);
    nrst = 1'h1;
    vcc_on = 1'h1;
    cap_en = 1'h1;
  endtask
  task automatic run_ovl(input int lim);
    logic pc;
    pc = 1'h0;
    n = 0;
    nc = 0;
    ext_rise = 8'(1 + $unsigned($random(seed)) % 4);
    fb_ovl = 1'h1;
    while (fire !== 1'h1 && n < lim)
    begin
      tick(1);
      n++;
      if (ecs === 1'h1 && !pc)
        nc++;
      pc = ecs;
    end
    fb_ovl = 1'h0;
  endtask
  initial
  begin
    {vcc_on, protect_active, restart_cycle, fb_ovl, fb_above_4v0, fb_above_3v5} = '0;
    {fb_below_3v2, fb_below_entry, extend_mode, cap_en, fb_rise} = '0;
    ext_rise = 8'h02;
    foreach (rs[i])
    begin
      boot(rs[i], 1'h0, 1'h0);
      tick(DC + 40);
      check(lv, 1);
      check({dflag, dds}, 0);
      check(lvl, exp_level(rs[i]));
    end
    boot(5, 1'h1, 1'h0);
    tick(DC + 40);
    check(lv, 0);
    check(lvl, LVL_NONE);
    boot(60, 1'h0, 1'h1);
    tick(DC + 40);
    check(lv, 0);
    protect_active = 1'h0;
    tick(DC + 40);
    cap_en = 1'h0;
    check(lvl, LVL_160);
    // a short dip must restart the burst blanking from zero
    extend_mode = 1'h1;
    fb_below_entry = 1'h1;
    tick(BL / 2 + $unsigned($random(seed)) % 10);
    fb_below_entry = 1'h0;
    tick(4);
    fb_below_entry = 1'h1;
    tick(BL - 2);
    check(ba, 0);
    tick(10);
    check(ba, 1);
    check(bias, 0);
    check(blim, 1);
    fb_below_entry = 1'h0;
    fb_above_3v5 = 1'h1;
    tick(6);
    check(bias, 1);
    fb_above_3v5 = 1'h0;
    fb_below_3v2 = 1'h1;
    tick(6);
    check(bias, 0);
    fb_below_3v2 = 1'h0;
    fb_above_4v0 = 1'h1;
    tick(6);
    check({ba, blim}, 0);
    fb_above_4v0 = 1'h0;
    extend_mode = 1'h0;
    run_ovl(5000);
    check(n >= BL + SPIKE_CYC && n <= BL + SPIKE_CYC + 8, 1);
    check(nc == 0, 1);
    check(edone, 0);
    tick(10);
    extend_mode = 1'h1;
    run_ovl(BL + 40);
    tick(6);
    check({fire, ecs, eds}, 0);
    check(nc > 0, 1);
    run_ovl(20000);
    check(fire, 1);
    check(edone, 1);
    check(nc == 256, 1);
    check(n > BL + SPIKE_CYC + 512, 1);
    tick(10);
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end
endmodule // fault_blanking_burst_select_tb_top
`default_nettype wire

// ===== fbb_caps.sv
`default_nettype none
module fbb_caps
(
  // clock and bench controls
  input wire logic ref_clk,
  input wire logic cap_en,
  input wire logic [7:0] fb_rise,
  input wire logic [7:0] ext_rise,
  // switches of the block
  input wire logic extend_charge_switch,
  input wire logic extend_discharge_switch,
  input wire logic detect_discharge_switch,
  // comparator levels
  output logic fb_hi,
  output logic fb_lo,
  output logic ext_upper_cmp,
  output logic ext_lower_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  int fb_v = 0;
  int ext_v = 0;
  // pin voltages as step counts; an idle extension pin keeps its charge
  always_ff @(posedge ref_clk)
  begin
    if (!cap_en)
      fb_v <= 0;
    else if (detect_discharge_switch)
      fb_v <= (fb_v > 0) ? fb_v - 1 : 0;
    else if (fb_v < int'(fb_rise))
      fb_v <= fb_v + 1;
    if (extend_discharge_switch && ext_v > 0)
      ext_v <= ext_v - 1;
    else if (extend_charge_switch && ext_v < int'(ext_rise))
      ext_v <= ext_v + 1;
  end
  assign fb_hi = cap_en && fb_v >= int'(fb_rise);
  assign fb_lo = cap_en && fb_v == 0;
  assign ext_upper_cmp = ext_v >= int'(ext_rise);
  assign ext_lower_cmp = ext_v == 0;
endmodule // fbb_caps
`default_nettype wire

// ===== fbb_chk_checker.sv
`default_nettype none
module fbb_chk
  import fbb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // watched pins
  input wire logic fb_above_4v0,
  input wire logic ext_upper_cmp,
  input wire logic ext_lower_cmp,
  input wire logic extend_charge_switch,
  input wire logic extend_discharge_switch,
  input wire logic detect_flag,
  input wire logic detect_discharge_switch,
  input wire logic [1:0] burst_level,
  input wire logic level_valid,
  input wire logic burst_active,
  input wire logic bias_on,
  input wire logic burst_limit_on,
  input wire logic restart_fire,
  input wire logic extension_done
);
  // slack for the synchroniser around the spike delay
  localparam int SP_LO = SPIKE_CYC - 2;
  localparam int SP_HI = SPIKE_CYC + 4;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  spike_delay_a:
    assert property ($rose(extension_done) |-> ##[SP_LO:SP_HI] restart_fire) else $error("late");
  fire_pulse_a:
    assert property (restart_fire |=> !restart_fire) else $error("long fire");
  switch_excl_a:
    assert property (!(extend_charge_switch && extend_discharge_switch)) else $error("both on");
  upper_stop_a:
    assert property (extend_charge_switch && ext_upper_cmp |-> ##[1:4] !extend_charge_switch)
    else $error("charge kept");
  lower_stop_a:
    assert property (extend_discharge_switch && ext_lower_cmp |-> ##[1:4] !extend_discharge_switch)
    else $error("discharge kept");
  detect_pair_a:
    assert property (detect_flag == detect_discharge_switch) else $error("flag apart");
  burst_bias_a:
    assert property ($rose(burst_active) |-> !bias_on) else $error("bias on");
  burst_exit_a:
    assert property (burst_active && fb_above_4v0 |-> ##[1:4] !burst_active) else $error("stay");
  limit_burst_a:
    assert property (burst_limit_on |-> burst_active && burst_level != LVL_NONE)
    else $error("limit");
  level_hold_a:
    assert property (level_valid |=> level_valid && $stable(burst_level)) else $error("relevel");
  done_idle_a:
    assert property (extension_done |-> !extend_charge_switch) else $error("charge after done");
  detect_window_a:
    assert property (detect_flag |-> !level_valid) else $error("flag after detection");
  cover property (restart_fire);
  cover property ($rose(burst_active));
  cover property ($rose(extension_done));
endmodule // fbb_chk
bind fbb_control fbb_chk i_chk (.ref_clk, .nrst, .fb_above_4v0, .ext_upper_cmp, .ext_lower_cmp,
  .extend_charge_switch, .extend_discharge_switch, .detect_flag, .detect_discharge_switch,
  .burst_level, .level_valid, .burst_active, .bias_on, .burst_limit_on, .restart_fire,
  .extension_done);
`default_nettype wire

// ===== fbb_control.sv
`default_nettype none
module fbb_control
  import fbb_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = BLANK_CYC,
  parameter int unsigned DETECT_CYCLES = DETECT_CYC,
  parameter logic [7:0] BOUND_HI = 8'h03,
  parameter logic [7:0] BOUND_MID = 8'h0a,
  parameter logic [7:0] BOUND_LO = 8'h28
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // supply and protection state
  input wire logic vcc_on,
  input wire logic protect_active,
  input wire logic restart_cycle,
  // feedback pin comparators
  input wire logic fb_above_4v5,
  input wire logic fb_above_4v0,
  input wire logic fb_above_3v5,
  input wire logic fb_below_3v2,
  input wire logic fb_below_entry,
  input wire logic fb_below_0v5,
  // extension pin comparators
  input wire logic ext_upper_cmp,
  input wire logic ext_lower_cmp,
  // extension mode select, high when a capacitor is fitted
  input wire logic extend_mode,
  // switches
  output logic extend_charge_switch,
  output logic extend_discharge_switch,
  output logic detect_discharge_switch,
  output logic detect_flag,
  // status
  output logic [1:0] burst_level,
  output logic level_valid,
  output logic burst_active,
  output logic bias_on,
  output logic burst_limit_on,
  output logic restart_fire,
  output logic extension_done
);
  fbb_sync_if cmp ();
  fbb_sync u_sync (.ref_clk(ref_clk), .nrst(nrst), .cmp(cmp));
  assign cmp.raw = {vcc_on, protect_active, fb_above_4v5, fb_above_4v0, fb_above_3v5,
    fb_below_3v2, fb_below_entry, fb_below_0v5, ext_upper_cmp, ext_lower_cmp};
  logic s_vcc, s_prot, s_4v5, s_4v0, s_3v5, s_3v2, s_entry, s_0v5, s_up, s_lo;
  assign {s_vcc, s_prot, s_4v5, s_4v0, s_3v5, s_3v2, s_entry, s_0v5, s_up, s_lo} =
    cmp.synced;

  // level detection
  fbb_det_e det_reg, det_next;
  logic [19:0] dtim_reg, dtim_next;
  logic [7:0] dcnt_reg, dcnt_next;
  logic [1:0] lvl_reg, lvl_next;
  logic lvalid_reg, lvalid_next, dflag_reg, dflag_next;
  always_comb
  begin
    det_next = det_reg;
    dtim_next = dtim_reg;
    dcnt_next = dcnt_reg;
    lvl_next = lvl_reg;
    lvalid_next = lvalid_reg;
    dflag_next = dflag_reg;
    case (det_reg)
      FBB_DET_WAIT:
      begin
        // restarts never rerun detection; protection postpones it
        if (s_vcc && !s_prot && !restart_cycle)
        begin
          det_next = FBB_DET_CHG;
          dtim_next = 20'h0_0000;
          dcnt_next = 8'h00;
        end
      end
      FBB_DET_CHG, FBB_DET_DIS:
      begin
        dtim_next = dtim_reg + 20'h0_0001;
        if (det_reg == FBB_DET_CHG && s_4v5)
        begin
          dflag_next = 1'b1;
          det_next = FBB_DET_DIS;
          if (dcnt_reg != 8'hff)
            dcnt_next = dcnt_reg + 8'h01;
        end
        else if (det_reg == FBB_DET_DIS && s_0v5)
        begin
          dflag_next = 1'b0;
          det_next = FBB_DET_CHG;
        end
        if (dtim_reg >= 20'(DETECT_CYCLES - 1))
        begin
          det_next = FBB_DET_DONE;
          dflag_next = 1'b0;
          lvalid_next = 1'b1;
          // small capacitor charges fast: many cycles means no burst
          if (dcnt_reg <= BOUND_HI)
            lvl_next = LVL_160;
          else if (dcnt_reg <= BOUND_MID)
            lvl_next = LVL_142;
          else if (dcnt_reg <= BOUND_LO)
            lvl_next = LVL_127;
          else
            lvl_next = LVL_NONE;
        end
      end
      FBB_DET_DONE: det_next = FBB_DET_DONE;
      default: det_next = FBB_DET_WAIT;
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      det_reg <= FBB_DET_WAIT;
      dtim_reg <= 20'h0_0000;
      dcnt_reg <= 8'h00;
      lvl_reg <= LVL_RESET;
      lvalid_reg <= 1'b0;
      dflag_reg <= 1'b0;
    end
    else
    begin
      det_reg <= det_next;
      dtim_reg <= dtim_next;
      dcnt_reg <= dcnt_next;
      lvl_reg <= lvl_next;
      lvalid_reg <= lvalid_next;
      dflag_reg <= dflag_next;
    end
  end
  // burst mode
  logic [19:0] btim_reg, btim_next;
  logic burst_reg, burst_next, bias_reg, bias_next, burst_ok;
  assign burst_ok = lvalid_reg && (lvl_reg != LVL_NONE);
  always_comb
  begin
    btim_next = 20'h0_0000;
    burst_next = burst_reg;
    bias_next = bias_reg;
    if (!burst_reg)
    begin
      bias_next = 1'b1;
      // fixed interval only; the extension never applies here
      if (burst_ok && s_entry)
      begin
        btim_next = btim_reg + 20'h0_0001;
        if (btim_reg >= 20'(BLANK_CYCLES - 1))
        begin
          burst_next = 1'b1;
          bias_next = 1'b0;
          btim_next = 20'h0_0000;
        end
      end
    end
    else if (s_4v0)
    begin
      burst_next = 1'b0;
      bias_next = 1'b1;
    end
    else if (s_3v5)
      bias_next = 1'b1;
    else if (s_3v2)
      bias_next = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      btim_reg <= 20'h0_0000;
      burst_reg <= 1'b0;
      bias_reg <= 1'b1;
    end
    else
    begin
      btim_reg <= btim_next;
      burst_reg <= burst_next;
      bias_reg <= bias_next;
    end
  end
  // overload blanking and extension
  fbb_ov_e ov_reg, ov_next;
  logic [19:0] otim_reg, otim_next;
  logic [8:0] ecnt_reg, ecnt_next;
  logic ext_done, gate_open;
  assign ext_done = (ecnt_reg == 9'(EXT_TOTAL));
  always_comb
  begin
    ov_next = ov_reg;
    otim_next = otim_reg;
    ecnt_next = ecnt_reg;
    gate_open = 1'b0;
    case (ov_reg)
      FBB_OV_IDLE:
      begin
        otim_next = 20'h0_0000;
        ecnt_next = 9'h000;
        if (s_4v5 && lvalid_reg)
          ov_next = FBB_OV_BLANK;
      end
      FBB_OV_BLANK:
      begin
        otim_next = otim_reg + 20'h0_0001;
        if (otim_reg >= 20'(BLANK_CYCLES - 1))
        begin
          otim_next = 20'h0_0000;
          if (extend_mode)
            ov_next = FBB_OV_CHG;
          else
            gate_open = 1'b1;
        end
      end
      FBB_OV_CHG:
        if (s_up && !ext_done)
        begin
          ecnt_next = ecnt_reg + 9'h001;
          ov_next = FBB_OV_DIS;
        end
        else if (ext_done)
          gate_open = 1'b1;
      FBB_OV_DIS:
        if (ext_done)
          gate_open = 1'b1;
        else if (s_lo)
          ov_next = FBB_OV_CHG;
      FBB_OV_SPIKE:
      begin
        otim_next = otim_reg + 20'h0_0001;
        if (otim_reg >= 20'(SPIKE_CYC - 1))
          ov_next = FBB_OV_FIRE;
      end
      FBB_OV_FIRE: ov_next = FBB_OV_IDLE;
      default: ov_next = FBB_OV_IDLE;
    endcase
    if (gate_open)
    begin
      ov_next = FBB_OV_SPIKE;
      otim_next = 20'h0_0000;
    end
    // overload gone before restart: drop counts, idle switches
    if (!s_4v5 && ov_reg != FBB_OV_IDLE && ov_reg != FBB_OV_FIRE)
    begin
      ov_next = FBB_OV_IDLE;
      otim_next = 20'h0_0000;
      ecnt_next = 9'h000;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ov_reg <= FBB_OV_IDLE;
      otim_reg <= 20'h0_0000;
      ecnt_reg <= 9'h000;
    end
    else
    begin
      ov_reg <= ov_next;
      otim_reg <= otim_next;
      ecnt_reg <= ecnt_next;
    end
  end
  // registered outputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      extend_charge_switch <= 1'b0;
      extend_discharge_switch <= 1'b0;
      detect_discharge_switch <= 1'b0;
      detect_flag <= 1'b0;
      burst_level <= LVL_RESET;
      level_valid <= 1'b0;
      burst_active <= 1'b0;
      bias_on <= 1'b1;
      burst_limit_on <= 1'b0;
      restart_fire <= 1'b0;
      extension_done <= 1'b0;
    end
    else
    begin
      extend_charge_switch <= (ov_next == FBB_OV_CHG) && !ext_done;
      extend_discharge_switch <= (ov_next == FBB_OV_DIS);
      detect_discharge_switch <= dflag_next;
      detect_flag <= dflag_next;
      burst_level <= lvl_next;
      level_valid <= lvalid_next;
      burst_active <= burst_next;
      bias_on <= bias_next;
      burst_limit_on <= burst_next && burst_ok;
      restart_fire <= (ov_next == FBB_OV_FIRE);
      extension_done <= (ecnt_next == 9'(EXT_TOTAL));
    end
  end
endmodule // fbb_control
`default_nettype wire

// ===== fbb_pkg.sv
`default_nettype none
package fbb_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BLANK_MS = 20;
  localparam int unsigned BLANK_CYC = CLK_HZ / 1000 * BLANK_MS;
  localparam int unsigned DETECT_MS = 1;
  localparam int unsigned DETECT_CYC = CLK_HZ / 1000 * DETECT_MS;
  localparam int unsigned SPIKE_US = 30;
  localparam int unsigned SPIKE_CYC = CLK_HZ / 1_000_000 * SPIKE_US;
  localparam int unsigned EXT_TOTAL = 256;
  localparam logic [1:0] LVL_160 = 2'h0;
  localparam logic [1:0] LVL_142 = 2'h1;
  localparam logic [1:0] LVL_127 = 2'h2;
  localparam logic [1:0] LVL_NONE = 2'h3;
  localparam logic [1:0] LVL_RESET = 2'h3;
  typedef enum logic [1:0] {
    FBB_DET_WAIT = 2'b00,
    FBB_DET_CHG = 2'b01,
    FBB_DET_DIS = 2'b10,
    FBB_DET_DONE = 2'b11
  } fbb_det_e;
  typedef enum logic [2:0] {
    FBB_OV_IDLE = 3'b000,
    FBB_OV_BLANK = 3'b001,
    FBB_OV_CHG = 3'b010,
    FBB_OV_DIS = 3'b011,
    FBB_OV_SPIKE = 3'b100,
    FBB_OV_FIRE = 3'b101
  } fbb_ov_e;
endpackage
`default_nettype wire

// ===== fbb_sync.sv
`default_nettype none
module fbb_sync
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // comparator lines
  fbb_sync_if.sync cmp
);
  logic [9:0] meta_reg;
  logic [9:0] meta_next;
  logic [9:0] sync_reg;
  logic [9:0] sync_next;
  genvar i;
  generate
    for (i = 0; i < 10; i++)
    begin : g_bit
      always_comb
      begin
        meta_next[i] = cmp.raw[i];
        sync_next[i] = meta_reg[i];
      end
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 10'h000;
      sync_reg <= 10'h000;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end
  assign cmp.synced = sync_reg;
endmodule // fbb_sync
`default_nettype wire

// ===== fbb_sync_if.sv
`default_nettype none
interface fbb_sync_if;
  logic [9:0] raw;
  logic [9:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface
`default_nettype wire
